// >>> host_bus_pkg.sv
package host_bus_pkg;

	// physical data bus width, taken from the width strap pins
	localparam logic [1:0] WIDTH_8  = 2'h0;
	localparam logic [1:0] WIDTH_16 = 2'h1;
	localparam logic [1:0] WIDTH_32 = 2'h2;

	// active-low lane select patterns, bit i is lane i
	localparam logic [3:0] SEL_FULL  = 4'h0;
	localparam logic [3:0] SEL_LOWER = 4'hc;
	localparam logic [3:0] SEL_UPPER = 4'h3;
	localparam logic [3:0] SEL_BYTE0 = 4'he;
	localparam logic [3:0] SEL_BYTE1 = 4'hd;
	localparam logic [3:0] SEL_BYTE2 = 4'hb;
	localparam logic [3:0] SEL_BYTE3 = 4'h7;
	localparam logic [3:0] LANES_ALL = 4'hf;

	// byte offset of the queue data register reached by the data-port select
	localparam logic [15:0] DATA_PORT_ADDR = 16'h0008;

	// synchroniser depth and widths
	localparam int SYNC_STAGES = 2;
	localparam int ADDR_W      = 15;
	localparam int BASE_W      = 12;
	localparam int DATA_W      = 32;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_READ,
		ST_WRITE
	} xfer_state_t;

	// every pin that crosses into the clk_i domain
	typedef struct packed {
		logic [1:0]        width_sel;
		logic [ADDR_W-1:0] addr;
		logic              addr_valid_qual_n;
		logic [3:0]        lane_select_n;
		logic              addr_strobe_n;
		logic              data_port_select_n;
		logic              async_read_strobe_n;
		logic              async_write_strobe_n;
		logic [DATA_W-1:0] data;
	} pin_bundle_t;

	// idle pins are high, so reset to all ones
	localparam pin_bundle_t PIN_RESET = '1;

endpackage

// >>> pin_sync_if.sv
`timescale 1ns/1ps
`default_nettype none

interface pin_sync_if;
	import host_bus_pkg::*;
	pin_bundle_t raw;
	pin_bundle_t synced;

	modport syncer (input raw, output synced);
	modport user (output raw, input synced);
endinterface : pin_sync_if

`default_nettype wire

// >>> pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync
	import host_bus_pkg::*;
(
	input  wire logic   clk_i,
	input  wire logic   rstn_i,
	input  wire logic   ce_i,
	pin_sync_if.syncer  pins
);

	typedef struct packed {
		pin_bundle_t [SYNC_STAGES-1:0] stage;
	} sync_state_t;

	sync_state_t state_reg;
	sync_state_t state_next;

	// shift chain; only the last stage leaves this module
	always_comb begin
		state_next = state_reg;
		if (ce_i) begin
			state_next.stage[0] = pins.raw;
			for (int i = 1; i < SYNC_STAGES; i++) begin
				state_next.stage[i] = state_reg.stage[i-1];
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= '{stage: {SYNC_STAGES{PIN_RESET}}};
		end else begin
			state_reg <= state_next;
		end
	end

	assign pins.synced = state_reg.stage[SYNC_STAGES-1];

endmodule // pin_sync

`default_nettype wire

// >>> host_bus_front.sv
// What the document requires of this block and its host
// RULE_01 - async and sync transfers may interleave but never overlap on shared pins
// RULE_02 - host keeps the synchronous bus clock at or below 50 MHz
// RULE_03 - in 32-bit mode accept byte, halfword and word transfers
// RULE_04 - in 16-bit mode accept byte and halfword only, never word
// RULE_05 - in 8-bit mode every transfer is a single byte
// RULE_06 - no byte swap between lanes, but upper halfword swaps onto lower lanes
// RULE_07 - 8-bit host ties its lines to both low lanes; 16-bit uses two
// RULE_08 - own decoder may claim only while address-valid qualifier is low
// RULE_09 - selects 0000 word, 0011 lower half, 1100 upper half (lane 0 first)
// RULE_10 - selects 0111, 1011, 1101, 1110 pick byte 0, 1, 2, 3
// RULE_11 - with data-port select low, lane selects ignored, access is 32-bit
// RULE_12 - upper lane selects and upper data lines unused outside 32-bit mode
// RULE_13 - strobe rising edge captures address 15:1, qualifier and lane selects
// RULE_14 - hit output is combinational: qualifier low and address 15:4 equals base
// RULE_15 - data-port select serves central decoding and exists only in 32-bit mode
// RULE_16 - data-port select bypasses decoder, reaches only queue data register, 32-bit
// RULE_17 - async transfers are single data; sync control inputs stay constant meanwhile
// RULE_18 - host with stable address ties the address strobe low
// RULE_19 - drive data lanes only on targeted reads, selected lanes; release otherwise
`timescale 1ns/1ps
`default_nettype none

module host_bus_front
	import host_bus_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rstn_i,
	input  wire logic              ce_i,
	input  wire logic [1:0]        width_sel_i,
	input  wire logic [BASE_W-1:0] base_addr_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic              addr_valid_qual_n_i,
	input  wire logic [3:0]        lane_select_n_i,
	input  wire logic              addr_strobe_n_i,
	input  wire logic              data_port_select_n_i,
	input  wire logic              async_read_strobe_n_i,
	input  wire logic              async_write_strobe_n_i,
	input  wire logic [DATA_W-1:0] host_data_lines_i,
	output logic      [DATA_W-1:0] host_data_lines_o,
	output logic      [3:0]        host_data_lines_oe_o,
	output logic                   local_target_hit_n_o,
	output logic                   acc_valid_o,
	output logic                   acc_write_o,
	output logic      [15:0]       acc_addr_o,
	output logic      [3:0]        acc_lanes_o,
	output logic      [DATA_W-1:0] acc_wdata_o,
	output logic                   acc_data_port_o,
	output logic                   size_error_o,
	input  wire logic [DATA_W-1:0] rd_data_i
);

	typedef struct packed {
		xfer_state_t       state;
		logic [ADDR_W-1:0] addr;
		logic              qual_n;
		logic [3:0]        sel_n;
		logic              rd_prev;
		logic              wr_prev;
		logic              swap;
		logic [3:0]        pin_lanes;
		logic [3:0]        acc_lanes;
		logic              acc_dport;
		logic [15:0]       acc_addr;
		logic              acc_valid;
		logic              acc_write;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] dout;
		logic [3:0]        oe;
		logic              size_err;
	} front_state_t;

	front_state_t state_reg;
	front_state_t state_next;
	pin_bundle_t  pin;
	pin_sync_if   sync_bus ();

	// every pin passes two flops before anything here looks at it
	assign sync_bus.raw = '{width_sel: width_sel_i, addr: addr_i,
		addr_valid_qual_n: addr_valid_qual_n_i, lane_select_n: lane_select_n_i,
		addr_strobe_n: addr_strobe_n_i, data_port_select_n: data_port_select_n_i,
		async_read_strobe_n: async_read_strobe_n_i,
		async_write_strobe_n: async_write_strobe_n_i, data: host_data_lines_i};
	assign pin = sync_bus.synced;

	pin_sync u_pin_sync (
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.ce_i   (ce_i),
		.pins   (sync_bus.syncer)
	);

	// returns {legal, lane enables} for a select pattern in a bus width
	function automatic logic [4:0] lane_decode(input logic [3:0] sel_n, input logic [1:0] width);
		logic [3:0] s;
		logic       ok;
		s  = (width == WIDTH_32) ? sel_n : {2'b11, sel_n[1:0]}; // RULE_12
		ok = 1'b0;
		if (width == WIDTH_32) begin
			ok = (s == SEL_FULL) || (s == SEL_LOWER) || (s == SEL_UPPER)  // RULE_03 RULE_09
				|| (s == SEL_BYTE0) || (s == SEL_BYTE1) || (s == SEL_BYTE2)
				|| (s == SEL_BYTE3); // RULE_10
		end else if (width == WIDTH_16) begin
			ok = (s == SEL_LOWER) || (s == SEL_BYTE0) || (s == SEL_BYTE1); // RULE_04
		end else if (width == WIDTH_8) begin
			ok = (s == SEL_BYTE0) || (s == SEL_BYTE1); // RULE_05 RULE_07
		end
		return {ok, ~s};
	endfunction

	logic       dport_sel;
	logic       local_hit;
	logic       claim;
	logic [4:0] dec;
	logic       narrow;
	logic       rd_fall;
	logic       wr_fall;
	logic       wr_rise;
	logic       rd_rise;

	// decode runs on the latched address so a strobed host sees a stable hit
	assign local_hit = !state_reg.qual_n && (state_reg.addr[ADDR_W-1:3] == base_addr_i); // RULE_08 RULE_14
	assign local_target_hit_n_o = ~local_hit; // RULE_14
	assign dport_sel = !pin.data_port_select_n && (pin.width_sel == WIDTH_32); // RULE_15
	assign narrow    = (pin.width_sel != WIDTH_32);
	assign dec       = lane_decode(state_reg.sel_n, pin.width_sel);
	assign claim     = dport_sel || local_hit; // RULE_16
	assign rd_fall   = state_reg.rd_prev && !pin.async_read_strobe_n;
	assign wr_fall   = state_reg.wr_prev && !pin.async_write_strobe_n;
	assign rd_rise   = !state_reg.rd_prev && pin.async_read_strobe_n;
	assign wr_rise   = !state_reg.wr_prev && pin.async_write_strobe_n;

	always_comb begin
		state_next = state_reg;
		if (ce_i) begin
			state_next.rd_prev   = pin.async_read_strobe_n;
			state_next.wr_prev   = pin.async_write_strobe_n;
			state_next.acc_valid = 1'b0;
			state_next.size_err  = 1'b0;

			// transparent while the strobe is low, frozen from its rising edge on
			if (!pin.addr_strobe_n) begin // RULE_13 RULE_18
				state_next.addr   = pin.addr;
				state_next.qual_n = pin.addr_valid_qual_n;
				state_next.sel_n  = pin.lane_select_n;
			end

			case (state_reg.state)
				ST_IDLE: begin
					state_next.oe = 4'h0;
					// both strobes falling in the same cycle is an overlap; nothing is claimed
					if ((rd_fall ^ wr_fall) && claim) begin // RULE_01 RULE_17
						if (dport_sel) begin
							state_next.acc_lanes = LANES_ALL; // RULE_11
							state_next.pin_lanes = LANES_ALL;
							state_next.acc_addr  = DATA_PORT_ADDR; // RULE_16
							state_next.swap      = 1'b0;
							state_next.acc_dport = 1'b1;
						end else begin
							// upper register half rides the lower lanes of a narrow bus
							state_next.swap      = narrow && state_reg.addr[0]; // RULE_06
							state_next.pin_lanes = dec[3:0];
							state_next.acc_lanes = (narrow && state_reg.addr[0]) ?
								{dec[1:0], 2'b00} : dec[3:0]; // RULE_06
							state_next.acc_addr  = {state_reg.addr, 1'b0};
							state_next.acc_dport = 1'b0;
						end
						if (!dport_sel && !dec[4]) begin
							state_next.size_err = 1'b1; // RULE_04 RULE_05
						end else if (rd_fall) begin
							state_next.state     = ST_READ;
							state_next.acc_valid = 1'b1;
							state_next.acc_write = 1'b0;
						end else begin
							state_next.state = ST_WRITE;
						end
					end
				end
				ST_READ: begin
					// read data follows the request by one cycle
					state_next.dout = state_reg.swap ?
						{rd_data_i[DATA_W-1:16], rd_data_i[DATA_W-1:16]} : rd_data_i; // RULE_06
					state_next.oe   = state_reg.pin_lanes; // RULE_19
					if (rd_rise) begin
						state_next.oe    = 4'h0; // RULE_19
						state_next.state = ST_IDLE;
					end
				end
				ST_WRITE: begin
					state_next.oe = 4'h0;
					// host data is taken on the write strobe's rising edge
					if (wr_rise) begin
						state_next.wdata     = state_reg.swap ?
							{pin.data[15:0], pin.data[15:0]} : pin.data; // RULE_06
						state_next.acc_valid = 1'b1;
						state_next.acc_write = 1'b1;
						state_next.state     = ST_IDLE;
					end
				end
				default: begin
					state_next.state = ST_IDLE;
					state_next.oe    = 4'h0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= '{state: ST_IDLE, qual_n: 1'b1, sel_n: 4'hf, rd_prev: 1'b1,
				wr_prev: 1'b1, default: '0};
		end else begin
			state_reg <= state_next;
		end
	end

	assign host_data_lines_o    = state_reg.dout;
	assign host_data_lines_oe_o = state_reg.oe;
	assign acc_valid_o          = state_reg.acc_valid;
	assign acc_write_o          = state_reg.acc_write;
	assign acc_addr_o           = state_reg.acc_addr;
	assign acc_lanes_o          = state_reg.acc_lanes;
	assign acc_wdata_o          = state_reg.wdata;
	assign acc_data_port_o      = state_reg.acc_dport;
	assign size_error_o         = state_reg.size_err;

endmodule // host_bus_front

`default_nettype wire

// >>> host_bus_front_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus_front_assertions
	import host_bus_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rstn_i,
	input wire logic [1:0]  width_sel_i,
	input wire logic        async_read_strobe_n_i,
	input wire logic        async_write_strobe_n_i,
	input wire logic [3:0]  host_data_lines_oe_o,
	input wire logic        acc_valid_o,
	input wire logic        acc_write_o,
	input wire logic [15:0] acc_addr_o,
	input wire logic [3:0]  acc_lanes_o,
	input wire logic        acc_data_port_o,
	input wire logic        size_error_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// a request is one cycle and is never followed by a refusal
	one_pulse_a:
	assert property (acc_valid_o |=> !acc_valid_o && !size_error_o) else $error("request pulse");
	// data port only on the wide bus, always the whole queue word
	data_port_a:
	assert property (acc_valid_o && acc_data_port_o |-> acc_lanes_o == LANES_ALL
		&& acc_addr_o == DATA_PORT_ADDR && width_sel_i == WIDTH_32) else $error("data port access");
	byte_bus_a:
	assert property (acc_valid_o && width_sel_i == WIDTH_8 |-> $onehot(acc_lanes_o)) else $error("byte bus lanes");
	half_bus_a:
	assert property (acc_valid_o && width_sel_i == WIDTH_16 |-> acc_lanes_o != LANES_ALL) else $error("half bus");
	// requests trail the strobe edge by the synchroniser delay, so no overlap
	read_edge_a:
	assert property (acc_valid_o && !acc_write_o |-> !$past(async_read_strobe_n_i, 3)
		&& $past(async_read_strobe_n_i, 5)) else $error("read request timing");
	write_edge_a:
	assert property (acc_valid_o && acc_write_o |-> $past(async_write_strobe_n_i, 3)
		&& !$past(async_write_strobe_n_i, 5)) else $error("write request timing");
	// lanes driven only inside a read, the selected ones on the wide bus
	oe_read_a:
	assert property (host_data_lines_oe_o != 4'h0 |-> !$past(async_read_strobe_n_i, 4)) else $error("lanes driven");
	oe_lanes_a:
	assert property (acc_valid_o && !acc_write_o && width_sel_i == WIDTH_32 |=> host_data_lines_oe_o == acc_lanes_o)
		else $error("read lanes");
	// main scenarios
	cover property (acc_valid_o && acc_write_o);
	cover property (size_error_o);
	cover property (acc_valid_o && acc_data_port_o);
endmodule // host_bus_front_assertions
`default_nettype wire

// >>> host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model
	import host_bus_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic [DATA_W-1:0] dout_i,
	input  wire logic [3:0]        oe_i,
	output var logic  [ADDR_W-1:0] addr_o,
	output var logic               qual_n_o,
	output var logic  [3:0]        sel_n_o,
	output var logic               strobe_n_o,
	output var logic               dport_n_o,
	output var logic               rd_n_o,
	output var logic               wr_n_o,
	output logic      [DATA_W-1:0] data_o
);
	logic [DATA_W-1:0] drv;
	logic [DATA_W-1:0] got;
	// device wins on lanes it enables; else the host's own value, inverted after each transfer so never a stale copy
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			data_o[8*k+:8] = oe_i[k] ? dout_i[8*k+:8] : drv[8*k+:8];
		end
	end
	initial begin
		{addr_o, qual_n_o, sel_n_o, strobe_n_o, dport_n_o, rd_n_o, wr_n_o, drv} = '1;
	end
	// one transfer at a time; the address is latched, then scrambled on the pins
	task automatic cyc(input logic w, input logic [15:0] a, input logic q, input logic [3:0] s, input logic dp,
		input logic [DATA_W-1:0] d);
		@(negedge clk_i);
		{addr_o, qual_n_o, sel_n_o, strobe_n_o} = {a[15:1], q, s, 1'h0};
		repeat (6) @(negedge clk_i);
		strobe_n_o = 1'h1;
		repeat (3) @(negedge clk_i);
		{addr_o, qual_n_o, sel_n_o} = ~{a[15:1], q, s};
		{dport_n_o, drv} = {dp, d};
		{rd_n_o, wr_n_o} = {w, !w};
		repeat (6) @(negedge clk_i);
		got = data_o;
		{rd_n_o, wr_n_o} = 2'h3;
		repeat (4) @(negedge clk_i);
		{dport_n_o, drv} = {1'h1, ~drv};
		repeat (4) @(negedge clk_i);
	endtask
endmodule // host_model
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import host_bus_pkg::*;
	typedef struct packed {
		logic [2:0] ctl; logic [1:0] wid; logic [15:0] a; logic [3:0] sel;
		logic [31:0] d; logic [1:0] res; logic [3:0] el; logic [31:0] ed;
	} row_t;
	localparam logic [31:0] RD = 32'ha5b6c7d8;
	// ctl is {write, qualifier_n, data_port_n}; res is {size error, request}
	row_t rows [14] = '{
		'{3'h5, WIDTH_32, 16'h1234, SEL_FULL,  32'h11223344, 2'h1, 4'hf, 32'h11223344},
		'{3'h1, WIDTH_32, 16'h1230, SEL_UPPER, 32'h0,        2'h1, 4'hc, RD},
		'{3'h1, WIDTH_32, 16'h1238, SEL_BYTE2, 32'h0,        2'h1, 4'h4, RD},
		'{3'h5, WIDTH_32, 16'h123c, SEL_BYTE3, 32'hcafe0000, 2'h1, 4'h8, 32'hcafe0000},
		'{3'h5, WIDTH_32, 16'h1234, SEL_BYTE0, 32'h000000e1, 2'h1, 4'h1, 32'h000000e1},
		'{3'h6, WIDTH_32, 16'h2234, SEL_BYTE0, 32'h76543210, 2'h1, 4'hf, 32'h76543210},
		'{3'h7, WIDTH_32, 16'h1234, SEL_FULL,  32'h0,        2'h0, 4'h0, 32'h0},
		'{3'h5, WIDTH_32, 16'h2234, SEL_FULL,  32'h0,        2'h0, 4'h0, 32'h0},
		'{3'h5, WIDTH_16, 16'h1236, SEL_LOWER, 32'h0000beef, 2'h1, 4'hc, 32'hbeefbeef},
		'{3'h1, WIDTH_16, 16'h1232, SEL_LOWER, 32'h0,        2'h1, 4'hc, 32'h0000a5b6},
		'{3'h5, WIDTH_16, 16'h1230, SEL_UPPER, 32'h0,        2'h2, 4'h0, 32'h0},
		'{3'h6, WIDTH_16, 16'h2234, SEL_FULL,  32'h0,        2'h0, 4'h0, 32'h0},
		'{3'h5, WIDTH_8,  16'h1234, SEL_BYTE1, 32'h00005a5a, 2'h1, 4'h2, 32'h00005a5a},
		'{3'h5, WIDTH_8,  16'h1234, SEL_LOWER, 32'h0,        2'h2, 4'h0, 32'h0}
	};
	logic clk_i, rstn_i, ce_i, addr_valid_qual_n_i, addr_strobe_n_i, data_port_select_n_i;
	logic async_read_strobe_n_i, async_write_strobe_n_i, local_target_hit_n_o;
	logic acc_valid_o, acc_write_o, acc_data_port_o, size_error_o;
	logic [1:0] width_sel_i;
	logic [ADDR_W-1:0] addr_i;
	logic [3:0] lane_select_n_i, host_data_lines_oe_o, acc_lanes_o;
	logic [DATA_W-1:0] host_data_lines_i, host_data_lines_o, acc_wdata_o, m;
	logic [15:0] acc_addr_o;
	int miscompares, n_tests, nv, ne, ticks;
	row_t r;
	host_bus_front dut (.clk_i, .rstn_i, .ce_i, .width_sel_i, .base_addr_i(12'h123), .addr_i,
		.addr_valid_qual_n_i, .lane_select_n_i, .addr_strobe_n_i, .data_port_select_n_i, .async_read_strobe_n_i,
		.async_write_strobe_n_i, .host_data_lines_i, .host_data_lines_o, .host_data_lines_oe_o, .local_target_hit_n_o,
		.acc_valid_o, .acc_write_o, .acc_addr_o, .acc_lanes_o, .acc_wdata_o, .acc_data_port_o, .size_error_o,
		.rd_data_i(RD));
	host_model host (.clk_i, .dout_i(host_data_lines_o), .oe_i(host_data_lines_oe_o), .addr_o(addr_i),
		.qual_n_o(addr_valid_qual_n_i), .sel_n_o(lane_select_n_i), .strobe_n_o(addr_strobe_n_i),
		.dport_n_o(data_port_select_n_i), .rd_n_o(async_read_strobe_n_i), .wr_n_o(async_write_strobe_n_i),
		.data_o(host_data_lines_i));
	initial begin
		clk_i = 1'h0;
		// host paced at 50 MHz, the ceiling for synchronous accesses
		forever #10 clk_i = ~clk_i;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// pulse counters, and a ceiling far above the few hundred cycles the run needs
	always @(posedge clk_i) begin
		nv += acc_valid_o;
		ne += size_error_o;
		ticks++;
		if (ticks == 5000) begin
			miscompares++;
			print_verdict();
		end
	end
	initial begin
		{rstn_i, width_sel_i, miscompares, n_tests, ticks} = '0;
		ce_i = 1'h1;
		repeat (5) @(negedge clk_i);
		chk("oe in reset", 32'h0, host_data_lines_oe_o);
		chk("hit in reset", 32'h1, local_target_hit_n_o);
		rstn_i = 1'h1;
		foreach (rows[i]) begin
			r = rows[i];
			width_sel_i = r.wid;
			{nv, ne} = '0;
			host.cyc(r.ctl[2], r.a, r.ctl[1], r.sel, r.ctl[0], r.d);
			m = (r.ctl[2] || r.wid == WIDTH_32) ? {{8{r.el[3]}}, {8{r.el[2]}}, {8{r.el[1]}}, {8{r.el[0]}}} : 32'h0000ffff;
			chk("requests", r.res[0], nv);
			chk("size errors", r.res[1], ne);
			if (r.res[0]) begin
				chk("address", r.ctl[0] ? r.a : DATA_PORT_ADDR, acc_addr_o);
				chk("lanes", r.el, acc_lanes_o);
				chk("direction", r.ctl[2], acc_write_o);
				chk("data port flag", !r.ctl[0], acc_data_port_o);
				chk("data", r.ed & m, (r.ctl[2] ? acc_wdata_o : host.got) & m);
			end
		end
		// read left open, then a reset lands in its middle
		width_sel_i = WIDTH_32;
		// enable held low through a whole claimable read: nothing may move
		ce_i = 1'h0;
		{nv, ne} = '0;
		host.cyc(1'h0, 16'h1234, 1'h0, SEL_FULL, 1'h1, 32'h0);
		ce_i = 1'h1;
		repeat (4) @(negedge clk_i);
		chk("requests with enable low", 32'h0, nv + ne);
		chk("lanes with enable low", 32'h0, host_data_lines_oe_o);
		// stable-address host: strobe tied low, latch stays transparent
		{host.addr_o, host.qual_n_o, host.sel_n_o, host.strobe_n_o} = {15'h0918, 1'h0, SEL_FULL, 1'h0};
		repeat (4) @(negedge clk_i);
		host.rd_n_o = 1'h0;
		repeat (8) @(negedge clk_i);
		chk("oe in read", 32'hf, host_data_lines_oe_o);
		chk("hit in read", 32'h0, local_target_hit_n_o);
		rstn_i = 1'h0;
		#1 chk("oe at reset", 32'h0, host_data_lines_oe_o);
		chk("hit at reset", 32'h1, local_target_hit_n_o);
		{host.rd_n_o, host.qual_n_o} = 2'h3;
		{nv, ne} = '0;
		@(negedge clk_i);
		rstn_i = 1'h1;
		repeat (6) @(negedge clk_i);
		chk("requests after reset", 32'h0, nv);
		print_verdict();
	end
endmodule // tb
bind host_bus_front host_bus_front_assertions rule_chk (.clk_i, .rstn_i, .width_sel_i, .async_read_strobe_n_i,
	.async_write_strobe_n_i, .host_data_lines_oe_o, .acc_valid_o, .acc_write_o, .acc_addr_o, .acc_lanes_o,
	.acc_data_port_o, .size_error_o);
`default_nettype wire
